//--- rtl/srp_defines.svh
`ifndef SRP_DEFINES_SVH
`define SRP_DEFINES_SVH

// wishbone register byte offsets
`define SRP_REG_CTRL 8'h00
`define SRP_REG_STATUS 8'h04
`define SRP_REG_SELECT 8'h08
`define SRP_CTRL_RST 1'h1

// read/write field patterns, first protocol byte
`define SRP_FN_READ 8'hE8
`define SRP_FN_WRITE 8'h17

// command field codes
`define SRP_CMD_BURST_RD 5'h06
`define SRP_CMD_BURST_WR 5'h11
`define SRP_CMD_RD_CRC 5'h03
`define SRP_CMD_SET_ARB 5'h16
`define SRP_CMD_POLL_ARB 5'h09
`define SRP_CMD_RD_SEL 5'h05
`define SRP_CMD_WR_SEL 5'h0E
`define SRP_CMD_MASK_HI 2'h3

// protocol layout
`define SRP_PROTO_BITS 56
`define SRP_PCNT_CRC_SNAP 6'h2F
`define SRP_PCNT_LAST 6'h37
`define SRP_BIT_LAST 3'h7

// arbitration byte locations
`define SRP_ARB_ADDR_LO 19'h00000
`define SRP_ARB_ADDR_HI 19'h7FFFF

// crc feedback constant
`define SRP_CRC_POLY 8'hCC

// serial ram access length in clk cycles
`define SRP_RAM_CYC 2'h1

// synchroniser reset levels: sel, sclk, dq, ce_n, we_n, oe_n
`define SRP_SYNC_RST 6'h17

`endif

//--- rtl/srp_pkg.sv
package srp_pkg;
  typedef enum logic [3:0] {
    SRP_IDLE, SRP_PROTO, SRP_RD, SRP_WR, SRP_CRCO, SRP_POLL, SRP_SELR, SRP_SELW, SRP_HALT
  } srp_state_t;
endpackage : srp_pkg

//--- rtl/srp_arbiter.sv
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`include "srp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module srp_arbiter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ser_select_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  output logic ser_data_o,
  output logic ser_data_oe_o,
  output logic serial_drive_indicator_o,
  input wire logic [18:0] pb_addr_i,
  input wire logic pb_ce_n_i,
  input wire logic pb_oe_n_i,
  input wire logic pb_we_n_i,
  input wire logic [7:0] pb_data_i,
  output logic [7:0] pb_data_o,
  output logic pb_data_oe_o,
  output logic [18:0] ram_addr_o,
  output logic ram_ce_n_o,
  output logic ram_oe_n_o,
  output logic ram_we_n_o,
  input wire logic [7:0] ram_data_i,
  output logic [7:0] ram_data_o,
  output logic ram_data_oe_o
);
  import srp_pkg::*;

  function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
    logic fb;
    logic [7:0] t;
    fb = b ^ c[0];
    t = fb ? (c ^ `SRP_CRC_POLY) : c;
    return {fb, t[7:1]};
  endfunction : crc_bit

  function automatic logic sel_match(input logic [15:0] rx, input logic [15:0] cur,
                                     input logic set, input logic [15:0] mask);
    return !set || (((rx ^ cur) & mask) == 16'h0000);
  endfunction : sel_match

  // input synchronisers
  localparam logic [5:0] SYNC_RST = `SRP_SYNC_RST;
  logic [5:0] raw_in;
  logic [5:0] s1_ff, s2_ff, s3_ff, flt_ff, prv_ff;
  assign raw_in = {ser_select_i, ser_clk_i, ser_data_i, pb_ce_n_i, pb_we_n_i, pb_oe_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_ff[gi] <= SYNC_RST[gi];
          s2_ff[gi] <= SYNC_RST[gi];
          s3_ff[gi] <= SYNC_RST[gi];
          flt_ff[gi] <= SYNC_RST[gi];
          prv_ff[gi] <= SYNC_RST[gi];
        end else begin
          s1_ff[gi] <= raw_in[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi]) begin
            flt_ff[gi] <= s3_ff[gi];
          end
          prv_ff[gi] <= flt_ff[gi];
        end
      end
    end
  endgenerate

  logic ctrl_en_ff;
  logic ser_act, sclk_rise, sclk_fall, dq_in, pb_we_fall;
  assign ser_act = flt_ff[5] & ctrl_en_ff;
  assign sclk_rise = flt_ff[4] & ~prv_ff[4];
  assign sclk_fall = ~flt_ff[4] & prv_ff[4];
  assign dq_in = flt_ff[3];
  assign pb_we_fall = ~flt_ff[1] & prv_ff[1] & ~flt_ff[2];

  // serial state
  srp_state_t state_ff;
  logic [5:0] pcnt_ff;
  logic [2:0] cnt_ff;
  logic [55:0] proto_ff;
  logic [7:0] sh_ff, crc_ff, crc_chk_ff, crc_saved_ff, sel_lo_ff;
  logic [18:0] addr_ff;
  logic [15:0] sel_bits_ff, mask_ff;
  logic sel_set_ff, byte_idx_ff, arb_loc_ff;
  logic [1:0] phase_ff;
  logic [2:0] s_flags_ff;
  logic [1:0] b_flags_ff;
  logic req_rd_ff, req_wr_ff;
  logic [18:0] req_addr_ff;
  logic [7:0] req_data_ff, rd_data_ff;
  logic rd_done_ff;

  logic [55:0] nxt_proto;
  logic [7:0] nxt_sh_in, nxt_crc_rx, nxt_crc_tx;
  logic [7:0] arb_byte;
  logic [2:0] count_bits;
  logic [7:0] p_fn, p_crc;
  logic [18:0] p_addr;
  logic [4:0] p_cmd;
  logic [15:0] p_sel, p_mask;
  logic p_rd, p_wr, p_ok, p_match;

  assign nxt_proto = {dq_in, proto_ff[55:1]};
  assign nxt_sh_in = {dq_in, sh_ff[7:1]};
  assign nxt_crc_rx = crc_bit(crc_ff, dq_in);
  assign nxt_crc_tx = crc_bit(crc_ff, sh_ff[0]);
  assign p_fn = nxt_proto[7:0];
  assign p_addr = nxt_proto[26:8];
  assign p_cmd = nxt_proto[31:27];
  assign p_sel = nxt_proto[47:32];
  assign p_crc = nxt_proto[55:48];
  assign p_rd = (p_fn == `SRP_FN_READ);
  assign p_wr = (p_fn == `SRP_FN_WRITE);
  assign p_ok = (p_crc == crc_chk_ff) && (p_rd || p_wr);
  assign p_match = sel_match(p_sel, sel_bits_ff, sel_set_ff, 16'hFFFF);
  assign p_mask = ~(16'hFFFF << {p_cmd[2:0], 1'b0});
  assign count_bits = (state_ff == SRP_PROTO) ? pcnt_ff[2:0] : cnt_ff;
  assign arb_byte = {s_flags_ff, b_flags_ff, count_bits};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= SRP_IDLE;
      pcnt_ff <= 6'h00;
      cnt_ff <= 3'h0;
      proto_ff <= 56'h0;
      sh_ff <= 8'h00;
      crc_ff <= 8'h00;
      crc_chk_ff <= 8'h00;
      crc_saved_ff <= 8'h00;
      sel_lo_ff <= 8'h00;
      addr_ff <= 19'h00000;
      sel_bits_ff <= 16'h0000;
      mask_ff <= 16'hFFFF;
      sel_set_ff <= 1'b0;
      byte_idx_ff <= 1'b0;
      arb_loc_ff <= 1'b0;
      phase_ff <= 2'h0;
      s_flags_ff <= 3'h0;
      req_rd_ff <= 1'b0;
      req_wr_ff <= 1'b0;
      req_addr_ff <= 19'h00000;
      req_data_ff <= 8'h00;
    end else begin
      req_rd_ff <= 1'b0;
      req_wr_ff <= 1'b0;
      if (!ser_act) begin
        if (state_ff != SRP_IDLE) begin
          crc_saved_ff <= crc_ff;
        end
        state_ff <= SRP_IDLE;
        cnt_ff <= 3'h0;
      end else if (state_ff == SRP_IDLE) begin
        state_ff <= SRP_PROTO;
        pcnt_ff <= 6'h00;
        cnt_ff <= 3'h0;
        crc_ff <= 8'h00;
      end else begin
        if (rd_done_ff && state_ff == SRP_RD) begin
          sh_ff <= rd_data_ff;
        end
        if (sclk_rise) begin
          case (state_ff)
            SRP_PROTO: begin
              proto_ff <= nxt_proto;
              crc_ff <= nxt_crc_rx;
              pcnt_ff <= pcnt_ff + 6'h01;
              if (pcnt_ff == `SRP_PCNT_CRC_SNAP) begin
                crc_chk_ff <= nxt_crc_rx;
              end
              if (pcnt_ff == `SRP_PCNT_LAST) begin
                cnt_ff <= 3'h0;
                addr_ff <= p_addr;
                byte_idx_ff <= 1'b0;
                phase_ff <= 2'h0;
                state_ff <= SRP_HALT;
                if (!p_ok) begin
                  state_ff <= SRP_HALT;
                end else if (p_rd && p_cmd == `SRP_CMD_BURST_RD && p_match) begin
                  state_ff <= SRP_RD;
                  req_rd_ff <= 1'b1;
                  req_addr_ff <= p_addr;
                end else if (p_rd && p_cmd[4:3] == `SRP_CMD_MASK_HI
                             && sel_match(p_sel, sel_bits_ff, sel_set_ff, p_mask)) begin
                  state_ff <= SRP_RD;
                  req_rd_ff <= 1'b1;
                  req_addr_ff <= p_addr;
                end else if (p_wr && p_cmd == `SRP_CMD_BURST_WR && p_match) begin
                  state_ff <= SRP_WR;
                end else if (p_rd && p_cmd == `SRP_CMD_RD_CRC && p_match) begin
                  state_ff <= SRP_CRCO;
                  sh_ff <= crc_saved_ff;
                end else if (p_wr && p_cmd == `SRP_CMD_SET_ARB && p_match) begin
                  if (p_addr == `SRP_ARB_ADDR_LO) begin
                    arb_loc_ff <= 1'b0;
                  end else if (p_addr == `SRP_ARB_ADDR_HI) begin
                    arb_loc_ff <= 1'b1;
                  end
                end else if (p_wr && p_cmd == `SRP_CMD_POLL_ARB && p_match) begin
                  state_ff <= SRP_POLL;
                  sh_ff <= arb_byte;
                end else if (p_rd && p_cmd == `SRP_CMD_RD_SEL) begin
                  state_ff <= SRP_SELR;
                  sh_ff <= sel_bits_ff[7:0];
                end else if (p_wr && p_cmd == `SRP_CMD_WR_SEL && p_match) begin
                  state_ff <= SRP_SELW;
                end
              end
            end
            SRP_RD: begin
              sh_ff <= {1'b0, sh_ff[7:1]};
              crc_ff <= nxt_crc_tx;
              cnt_ff <= cnt_ff + 3'h1;
              if (cnt_ff == `SRP_BIT_LAST) begin
                addr_ff <= addr_ff + 19'h00001;
                req_rd_ff <= 1'b1;
                req_addr_ff <= addr_ff + 19'h00001;
              end
            end
            SRP_WR: begin
              sh_ff <= nxt_sh_in;
              crc_ff <= nxt_crc_rx;
              cnt_ff <= cnt_ff + 3'h1;
              if (cnt_ff == `SRP_BIT_LAST) begin
                req_wr_ff <= 1'b1;
                req_addr_ff <= addr_ff;
                req_data_ff <= nxt_sh_in;
                addr_ff <= addr_ff + 19'h00001;
              end
            end
            SRP_CRCO: begin
              sh_ff <= {1'b0, sh_ff[7:1]};
              cnt_ff <= cnt_ff + 3'h1;
              if (cnt_ff == `SRP_BIT_LAST) begin
                state_ff <= SRP_HALT;
              end
            end
            SRP_SELR: begin
              sh_ff <= {1'b0, sh_ff[7:1]};
              cnt_ff <= cnt_ff + 3'h1;
              if (cnt_ff == `SRP_BIT_LAST) begin
                byte_idx_ff <= 1'b1;
                sh_ff <= sel_bits_ff[15:8];
                if (byte_idx_ff) begin
                  state_ff <= SRP_HALT;
                end
              end
            end
            SRP_SELW: begin
              sh_ff <= nxt_sh_in;
              cnt_ff <= cnt_ff + 3'h1;
              if (cnt_ff == `SRP_BIT_LAST) begin
                byte_idx_ff <= 1'b1;
                sel_lo_ff <= nxt_sh_in;
                if (byte_idx_ff) begin
                  sel_bits_ff <= {nxt_sh_in, sel_lo_ff};
                  sel_set_ff <= 1'b1;
                  state_ff <= SRP_HALT;
                end
              end
            end
            SRP_POLL: begin
              cnt_ff <= cnt_ff + 3'h1;
              if (phase_ff == 2'h1) begin
                sh_ff <= nxt_sh_in;
                crc_ff <= nxt_crc_rx;
              end else begin
                sh_ff <= {1'b0, sh_ff[7:1]};
                crc_ff <= nxt_crc_tx;
              end
              if (cnt_ff == `SRP_BIT_LAST) begin
                phase_ff <= phase_ff + 2'h1;
                if (phase_ff == 2'h1) begin
                  s_flags_ff <= nxt_sh_in[7:5];
                  sh_ff <= {nxt_sh_in[7:5], b_flags_ff, 3'h0};
                end else if (phase_ff == 2'h2) begin
                  state_ff <= SRP_HALT;
                end
              end
            end
            default: begin
              cnt_ff <= cnt_ff;
            end
          endcase
        end
      end
    end
  end

  // serial data output, changed after falling clock
  logic out_state;
  assign out_state = (state_ff == SRP_RD) || (state_ff == SRP_CRCO) || (state_ff == SRP_SELR)
                     || (state_ff == SRP_POLL && phase_ff != 2'h1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_data_o <= 1'b0;
      ser_data_oe_o <= 1'b0;
      serial_drive_indicator_o <= 1'b0;
    end else if (!ser_act || !out_state) begin
      ser_data_oe_o <= 1'b0;
      serial_drive_indicator_o <= 1'b0;
    end else if (sclk_fall) begin
      ser_data_o <= sh_ff[0];
      ser_data_oe_o <= 1'b1;
      serial_drive_indicator_o <= 1'b1;
    end
  end

  // ram access sequencer and parallel passthrough
  logic [1:0] seq_cnt_ff;
  logic seq_wr_ff;
  logic arb_hit;
  assign arb_hit = (pb_addr_i == (arb_loc_ff ? `SRP_ARB_ADDR_HI : `SRP_ARB_ADDR_LO));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_cnt_ff <= 2'h0;
      seq_wr_ff <= 1'b0;
      rd_done_ff <= 1'b0;
      rd_data_ff <= 8'h00;
      ram_addr_o <= 19'h00000;
      ram_ce_n_o <= 1'b1;
      ram_oe_n_o <= 1'b1;
      ram_we_n_o <= 1'b1;
      ram_data_o <= 8'h00;
      ram_data_oe_o <= 1'b0;
    end else begin
      rd_done_ff <= 1'b0;
      if (req_rd_ff || req_wr_ff) begin
        seq_cnt_ff <= `SRP_RAM_CYC;
        seq_wr_ff <= req_wr_ff;
        ram_addr_o <= req_addr_ff;
        ram_ce_n_o <= 1'b0;
        ram_oe_n_o <= req_wr_ff;
        ram_we_n_o <= ~req_wr_ff;
        ram_data_o <= req_data_ff;
        ram_data_oe_o <= req_wr_ff;
      end else if (seq_cnt_ff != 2'h0) begin
        seq_cnt_ff <= seq_cnt_ff - 2'h1;
        if (seq_cnt_ff == 2'h1) begin
          ram_ce_n_o <= 1'b1;
          ram_oe_n_o <= 1'b1;
          ram_we_n_o <= 1'b1;
          ram_data_oe_o <= 1'b0;
          rd_done_ff <= ~seq_wr_ff;
          rd_data_ff <= ram_data_i;
        end
      end else if (!flt_ff[5]) begin
        ram_addr_o <= pb_addr_i;
        ram_ce_n_o <= pb_ce_n_i;
        ram_oe_n_o <= pb_oe_n_i | arb_hit;
        ram_we_n_o <= pb_we_n_i | arb_hit;
        ram_data_o <= pb_data_i;
        ram_data_oe_o <= ~pb_ce_n_i & ~pb_we_n_i & ~arb_hit;
      end else begin
        ram_ce_n_o <= 1'b1;
        ram_oe_n_o <= 1'b1;
        ram_we_n_o <= 1'b1;
        ram_data_oe_o <= 1'b0;
      end
    end
  end

  // parallel read data and parallel flag writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pb_data_o <= 8'h00;
      pb_data_oe_o <= 1'b0;
      b_flags_ff <= 2'h0;
    end else begin
      pb_data_o <= arb_hit ? arb_byte : ram_data_i;
      pb_data_oe_o <= ~pb_ce_n_i & ~pb_oe_n_i & pb_we_n_i & (arb_hit | ~flt_ff[5]);
      if (pb_we_fall && arb_hit) begin
        b_flags_ff <= pb_data_i[4:3];
      end
    end
  end

  // wishbone slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_en_ff <= `SRP_CTRL_RST;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_adr_i == `SRP_REG_CTRL) begin
          if (wb_we_i && wb_sel_i[0]) begin
            ctrl_en_ff <= wb_dat_i[0];
          end
          wb_dat_o <= {31'h0, ctrl_en_ff};
        end else if (wb_adr_i == `SRP_REG_STATUS) begin
          wb_dat_o <= {8'h00, crc_saved_ff, 3'h0, (state_ff != SRP_IDLE), 3'h0, arb_loc_ff,
                       arb_byte};
        end else if (wb_adr_i == `SRP_REG_SELECT) begin
          wb_dat_o <= {15'h0, sel_set_ff, sel_bits_ff};
        end
      end
    end
  end

endmodule : srp_arbiter

`default_nettype wire

//--- dv/srp_arbiter_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module srp_arbiter_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic ser_select_i,
  input wire logic ser_data_oe_o,
  input wire logic serial_drive_indicator_o,
  input wire logic [18:0] pb_addr_i,
  input wire logic pb_ce_n_i,
  input wire logic pb_oe_n_i,
  input wire logic pb_we_n_i,
  input wire logic [7:0] pb_data_i,
  input wire logic pb_data_oe_o,
  input wire logic [18:0] ram_addr_o,
  input wire logic ram_ce_n_o,
  input wire logic ram_we_n_o,
  input wire logic [7:0] ram_data_o,
  input wire logic ram_data_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  abort_drive_a: assert property (!ser_select_i [*6] |-> !ser_data_oe_o)
    else $error("serial data driven with select low");
  abort_ind_a: assert property (!ser_select_i [*7] |-> !serial_drive_indicator_o)
    else $error("drive indicator high with select low");
  drive_copy_a: assert property ($rose(ser_data_oe_o) |-> ##[0:1] serial_drive_indicator_o)
    else $error("drive indicator does not follow enable");
  pass_addr_a: assert property (!ser_select_i [*8] |=> ram_addr_o == $past(pb_addr_i))
    else $error("parallel address not passed to ram");
  pass_wr_a: assert property (!ser_select_i [*8] ##1 (!pb_ce_n_i && !pb_we_n_i
    && pb_addr_i != 19'h00000 && pb_addr_i != 19'h7FFFF)
    |=> !ram_we_n_o && ram_data_oe_o && ram_data_o == $past(pb_data_i))
    else $error("parallel write not passed to ram");
  pb_drive_a: assert property (pb_data_oe_o |-> $past(!pb_ce_n_i && !pb_oe_n_i && pb_we_n_i))
    else $error("parallel data driven without read");
  ram_wr_a: assert property (!ram_we_n_o |-> ram_data_oe_o && !ram_ce_n_o)
    else $error("ram write without data or enable");
endmodule : srp_arbiter_asserts

bind srp_arbiter srp_arbiter_asserts u_srp_arbiter_asserts (.*);

`default_nettype wire

//--- dv/srp_ram_model.sv
`timescale 1ns/1ps
`default_nettype none

module srp_ram_model (
  input wire logic clk_i,
  input wire logic [18:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o
);
  logic [7:0] mem [0:255];
  logic [7:0] last_ff = 8'h00;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  end

  // writes land while enable and write strobe are low
  always @(posedge clk_i) begin
    if (!ce_n_i && !we_n_i) mem[addr_i[7:0]] <= data_i;
    if (!ce_n_i && !oe_n_i && we_n_i) last_ff <= data_o;
  end

  // released bus shows the inverse of the last byte
  assign data_o = (!ce_n_i && !oe_n_i && we_n_i) ? mem[addr_i[7:0]] : ~last_ff;
endmodule : srp_ram_model

`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.svh"

module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic [3:0] wb_sel_i = 4'h0;
  logic ser_select_i = 1'b0, ser_clk_i = 1'b1, host_dq = 1'b1, ser_data_o, ser_data_oe_o;
  logic serial_drive_indicator_o, pb_ce_n_i = 1'b1, pb_oe_n_i = 1'b1, pb_we_n_i = 1'b1;
  logic [18:0] pb_addr_i = 19'h0, ram_addr_o;
  logic [7:0] pb_data_i = 8'h00, pb_data_o, ram_data_i, ram_data_o, crc, q, ex;
  logic pb_data_oe_o, ram_ce_n_o, ram_oe_n_o, ram_we_n_o, ram_data_oe_o;
  wire logic ser_data_i = (ser_data_oe_o === 1'b1) ? ser_data_o : host_dq;
  int bad_count = 0, check_count = 0, oe_cnt = 0, n;
  localparam logic [4:0] m_cmd [5] = '{5'h06, 5'h06, 5'h18, 5'h19, 5'h19};
  localparam logic [15:0] m_sel [5] = '{16'h0, 16'h1234, 16'h0, 16'hFFFC, 16'h0001};
  localparam logic [4:0] m_ok = 5'b01110;

  srp_arbiter u_srp_arbiter (.*);
  srp_ram_model u_srp_ram_model (.clk_i(clk_i), .addr_i(ram_addr_o), .ce_n_i(ram_ce_n_o),
    .oe_n_i(ram_oe_n_o), .we_n_i(ram_we_n_o), .data_i(ram_data_o), .data_o(ram_data_i));

  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (ser_data_oe_o === 1'b1) oe_cnt <= oe_cnt + 1;

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask : tick

  function automatic logic [7:0] crc_upd(input logic [7:0] c, input logic d);
    logic [7:0] t;
    t = (d ^ c[0]) ? c ^ `SRP_CRC_POLY : c;
    return {d ^ c[0], t[7:1]};
  endfunction : crc_upd

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    for (k = 0; k < 50 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: bus wait ran out", $time);
      summarize();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    tick(1);
  endtask : wb

  task automatic pb(input logic we, input logic [18:0] a, input logic [7:0] d,
                    output logic [7:0] rd);
    pb_addr_i <= a;
    pb_data_i <= d;
    pb_ce_n_i <= 1'b0;
    pb_oe_n_i <= we;
    pb_we_n_i <= !we;
    tick(4);
    rd = pb_data_o;
    pb_ce_n_i <= 1'b1;
    pb_oe_n_i <= 1'b1;
    pb_we_n_i <= 1'b1;
    tick(2);
  endtask : pb

  // one link clock: fall, drive, rise, sample wire late in high phase
  task automatic sbit(input logic d, output logic b);
    ser_clk_i <= 1'b0;
    host_dq <= d;
    tick(4);
    ser_clk_i <= 1'b1;
    tick(3);
    b = ser_data_i;
    crc = crc_upd(crc, b);
    tick(1);
  endtask : sbit

  task automatic sbyte(input logic [7:0] d, output logic [7:0] b);
    for (int i = 0; i < 8; i++) sbit(d[i], b[i]);
  endtask : sbyte

  task automatic start(input logic [7:0] fn, input logic [18:0] a, input logic [4:0] cmd,
                       input logic [15:0] sel, input logic bad);
    logic [55:0] p;
    logic [7:0] c;
    logic b;
    c = 8'h00;
    p = {8'h00, sel, cmd, a, fn};
    for (int i = 0; i < 48; i++) c = crc_upd(c, p[i]);
    p[55:48] = c ^ {7'h0, bad};
    crc = 8'h00;
    ser_select_i <= 1'b1;
    tick(60);
    for (int i = 0; i < 56; i++) sbit(p[i], b);
  endtask : start

  task automatic stop;
    ser_select_i <= 1'b0;
    tick(10);
  endtask : stop

  initial begin
    tick(4);
    rst_i <= 1'b0;
    tick(2);
    wb(1'b0, `SRP_REG_CTRL, 32'h0, r);
    chk(r, 32'h1);
    wb(1'b0, 8'h0C, 32'h0, r);
    chk(r, 32'h0);
    pb(1'b1, 19'h20, 8'h6B, q);
    pb(1'b0, 19'h20, 8'h00, q);
    chk(32'(q), 32'h6B);
    start(`SRP_FN_WRITE, 19'h10, `SRP_CMD_BURST_WR, 16'h0, 1'b0);
    sbyte(8'hA5, q);
    sbyte(8'h3C, q);
    for (int i = 0; i < 3; i++) sbit(1'b1, q[0]);
    stop();
    chk(32'(u_srp_ram_model.mem[8'h10]), 32'hA5);
    chk(32'(u_srp_ram_model.mem[8'h11]), 32'h3C);
    chk(32'(u_srp_ram_model.mem[8'h12]), 32'h48);
    for (int k = 0; k < 2; k++) begin
      start(k ? `SRP_FN_WRITE : 8'h00, 19'h12, `SRP_CMD_BURST_WR, 16'h0, k[0]);
      sbyte(8'hFF, q);
      stop();
      chk(32'(u_srp_ram_model.mem[8'h12]), 32'h48);
    end
    start(`SRP_FN_READ, 19'h10, `SRP_CMD_BURST_RD, 16'h0, 1'b0);
    sbyte(8'hFF, q);
    chk(32'(q), 32'hA5);
    sbyte(8'hFF, q);
    chk(32'(q), 32'h3C);
    ex = crc;
    stop();
    wb(1'b0, `SRP_REG_STATUS, 32'h0, r);
    chk(32'(r[23:16]), 32'(ex));
    start(`SRP_FN_READ, 19'h0, `SRP_CMD_RD_CRC, 16'h0, 1'b0);
    sbyte(8'hFF, q);
    chk(32'(q), 32'(ex));
    stop();
    for (int k = 0; k < 2; k++) begin
      start(`SRP_FN_WRITE, k ? `SRP_ARB_ADDR_HI : `SRP_ARB_ADDR_LO, `SRP_CMD_SET_ARB, 16'h0, 1'b0);
      stop();
      wb(1'b0, `SRP_REG_STATUS, 32'h0, r);
      chk(32'(r[8]), 32'(k));
    end
    start(`SRP_FN_WRITE, 19'h0, `SRP_CMD_POLL_ARB, 16'h0, 1'b0);
    sbyte(8'hFF, q);
    chk(32'(q[7:3]), 32'h0);
    sbyte(8'hFF, q);
    sbyte(8'hFF, q);
    chk(32'(q[7:3]), 32'h1C);
    stop();
    pb(1'b1, `SRP_ARB_ADDR_HI, 8'h18, q);
    pb(1'b0, `SRP_ARB_ADDR_HI, 8'h00, q);
    chk(32'(q[7:3]), 32'h1F);
    chk(32'(u_srp_ram_model.mem[8'hFF]), 32'hA5);
    start(`SRP_FN_READ, `SRP_ARB_ADDR_HI, `SRP_CMD_BURST_RD, 16'h0, 1'b0);
    sbyte(8'hFF, q);
    chk(32'(q), 32'hA5);
    stop();
    start(`SRP_FN_WRITE, 19'h0, `SRP_CMD_POLL_ARB, 16'h0, 1'b0);
    sbyte(8'hFF, q);
    sbyte(8'h00, q);
    sbyte(8'hFF, q);
    chk(32'(q[7:3]), 32'h03);
    stop();
    for (int k = 0; k < 2; k++) begin
      start(`SRP_FN_WRITE, 19'h0, `SRP_CMD_WR_SEL, 16'h0, 1'b0);
      sbyte(8'h34, q);
      sbyte(8'h12, q);
      stop();
      wb(1'b0, `SRP_REG_SELECT, 32'h0, r);
      chk(r, 32'h11234);
    end
    start(`SRP_FN_READ, 19'h0, `SRP_CMD_RD_SEL, 16'h0, 1'b0);
    sbyte(8'hFF, q);
    chk(32'(q), 32'h34);
    sbyte(8'hFF, q);
    chk(32'(q), 32'h12);
    stop();
    for (int k = 0; k < 5; k++) begin
      n = oe_cnt;
      start(`SRP_FN_READ, 19'h10, m_cmd[k], m_sel[k], 1'b0);
      sbyte(8'hFF, q);
      stop();
      if (m_ok[k]) chk(32'(q), 32'hA5);
      else chk(32'(oe_cnt - n), 32'h0);
    end
    summarize();
  end
endmodule : tb_top

`default_nettype wire
